// [include/uge_map.svh]
// uge_map.svh: offsets, field positions, reset values and timing counts of the USB global event block.
// assumes: included by its bare name; register indexes become byte addresses as index * 4.
//
// What this block does
// - reserved flag and enable bits read zero
// - line activity during suspend, except own resume, sets wake flag
// - wake flag with enable requests interrupt
// - bus reset end sets sticky flag
// - reset end flag with enable requests interrupt
// - each start of frame sets sticky flag
// - frame flag with enable requests interrupt
// - three milliseconds idle sets suspend flag
// - suspend flag with enable requests interrupt
// - reset end enable comes up set
`ifndef UGE_MAP_SVH
`define UGE_MAP_SVH

// register indexes
`define UGE_IDX_LINE_STATUS 8'hBC
`define UGE_IDX_EVENT_FLAGS 8'hBD
`define UGE_IDX_EVENT_ENABLES 8'hBE
`define UGE_IDX_EVENT_CLEAR 8'hBF

// field positions, shared by flags, enables and clear
`define UGE_BIT_WAKE 5
`define UGE_BIT_RESET_END 4
`define UGE_BIT_FRAME 3
`define UGE_BIT_SUSPEND 0

// line status fields
`define UGE_BIT_SUSPENDED 0
`define UGE_BIT_LINE_IDLE 1
`define UGE_BIT_IN_RESET 2
`define UGE_BIT_RESUMING 3

// writable positions and reset values
`define UGE_EVENT_MASK 8'h39
`define UGE_FLAGS_RESET 8'h00
`define UGE_ENABLES_RESET 8'h10

// timing
`define UGE_CLK_MHZ 10
`define UGE_SUSPEND_TIME_US 3000
`define UGE_SUSPEND_CYCLES (`UGE_SUSPEND_TIME_US * `UGE_CLK_MHZ)

`endif

// [include/uge_pkg.sv]
// uge_pkg.sv: types of the USB global event block.
// assumes: compiled before the design; used by scoped names only.
package uge_pkg;

	typedef enum logic [1:0] {
		UGE_LINK_ACTIVE,
		UGE_LINK_SUSPENDED,
		UGE_LINK_WAKING
	} uge_link_state_t;

	typedef logic [7:0] uge_reg_t;

endpackage : uge_pkg

// [logic/uge_irq.sv]
// uge_irq.sv: USB global event flags, their enables and the USB interrupt request.
// assumes: classic Wishbone master on clk_i; line inputs come from the serial engine's clock.
`include "uge_map.svh"
`timescale 1ns/1ns
`default_nettype none

module uge_irq #(
	parameter int unsigned SUSPEND_CYCLES = `UGE_SUSPEND_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       cyc_i,
	input  wire logic       stb_i,
	input  wire logic       we_i,
	input  wire logic [9:0] adr_i,
	input  wire logic [3:0] sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic       line_idle_i,
	input  wire logic       bus_reset_i,
	input  wire logic       frame_start_toggle_i,
	input  wire logic       upstream_resume_i,
	output logic            suspended_o,
	output logic            usb_irq_o
);

	// two-flop synchronisers for the line inputs
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic       frame_prev;
	logic       reset_prev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end else begin
			sync_a <= {upstream_resume_i, frame_start_toggle_i, bus_reset_i, line_idle_i};
			sync_b <= sync_a;
		end
	end

	logic line_idle;
	logic in_reset;
	logic frame_tgl;
	logic resuming;

	assign line_idle = sync_b[0];
	assign in_reset  = sync_b[1];
	assign frame_tgl = sync_b[2];
	assign resuming  = sync_b[3];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_prev <= 1'b0;
			reset_prev <= 1'b0;
		end else begin
			frame_prev <= frame_tgl;
			reset_prev <= in_reset;
		end
	end

	// event detection
	logic frame_event;
	logic reset_end_event;
	logic suspend_event;
	logic wake_event;

	assign frame_event     = frame_tgl ^ frame_prev;
	assign reset_end_event = reset_prev & ~in_reset;

	// idle counter for suspend
	logic [31:0]              idle_count;
	uge_pkg::uge_link_state_t link_state;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_count <= 32'h0000_0000;
		end else if (!line_idle || in_reset) begin
			idle_count <= 32'h0000_0000;
		end else if (idle_count < SUSPEND_CYCLES) begin
			idle_count <= idle_count + 32'h0000_0001;
		end
	end

	assign suspend_event = (link_state == uge_pkg::UGE_LINK_ACTIVE) && line_idle && !in_reset
		&& (idle_count == SUSPEND_CYCLES - 1);

	// own resume drives the line too, so it must not count as a wake
	assign wake_event = (link_state == uge_pkg::UGE_LINK_SUSPENDED) && !line_idle
		&& !resuming;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_state <= uge_pkg::UGE_LINK_ACTIVE;
		end else begin
			case (link_state)
				uge_pkg::UGE_LINK_ACTIVE: begin
					if (suspend_event) begin
						link_state <= uge_pkg::UGE_LINK_SUSPENDED;
					end
				end
				uge_pkg::UGE_LINK_SUSPENDED: begin
					if (wake_event) begin
						link_state <= uge_pkg::UGE_LINK_WAKING;
					end else if (!line_idle) begin
						link_state <= uge_pkg::UGE_LINK_WAKING;
					end
				end
				uge_pkg::UGE_LINK_WAKING: begin
					if (line_idle || in_reset) begin
						link_state <= uge_pkg::UGE_LINK_ACTIVE;
					end
				end
				default: begin
					link_state <= uge_pkg::UGE_LINK_ACTIVE;
				end
			endcase
		end
	end

	// wishbone decode
	logic       req;
	logic       wr_take;
	logic [7:0] idx;
	logic       hit_status;
	logic       hit_flags;
	logic       hit_enables;
	logic       hit_clear;

	assign req     = cyc_i & stb_i;
	assign wr_take = req & we_i & ack_o & sel_i[0];
	assign idx     = adr_i[9:2];

	always_comb begin
		hit_status  = 1'b0;
		hit_flags   = 1'b0;
		hit_enables = 1'b0;
		hit_clear   = 1'b0;
		if (idx == `UGE_IDX_LINE_STATUS) begin
			hit_status = 1'b1;
		end else if (idx == `UGE_IDX_EVENT_FLAGS) begin
			hit_flags = 1'b1;
		end else if (idx == `UGE_IDX_EVENT_ENABLES) begin
			hit_enables = 1'b1;
		end else if (idx == `UGE_IDX_EVENT_CLEAR) begin
			hit_clear = 1'b1;
		end
	end

	// flags and enables
	uge_pkg::uge_reg_t usb_event_flags;
	uge_pkg::uge_reg_t usb_event_enables;
	uge_pkg::uge_reg_t set_bits;
	uge_pkg::uge_reg_t clr_bits;
	uge_pkg::uge_reg_t next_flags;

	always_comb begin
		set_bits = 8'h00;
		set_bits[`UGE_BIT_WAKE]      = wake_event;
		set_bits[`UGE_BIT_RESET_END] = reset_end_event;
		set_bits[`UGE_BIT_FRAME]     = frame_event;
		set_bits[`UGE_BIT_SUSPEND]   = suspend_event;
		clr_bits = 8'h00;
		if (wr_take && hit_flags) begin
			clr_bits = ~dat_i[7:0];
		end else if (wr_take && hit_clear) begin
			clr_bits = dat_i[7:0];
		end
		next_flags = ((usb_event_flags & ~clr_bits) | set_bits) & `UGE_EVENT_MASK;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_event_flags <= `UGE_FLAGS_RESET;
		end else begin
			usb_event_flags <= next_flags;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_event_enables <= `UGE_ENABLES_RESET;
		end else if (wr_take && hit_enables) begin
			usb_event_enables <= dat_i[7:0] & `UGE_EVENT_MASK;
		end
	end

	// interrupt request, from next flags and next enables
	uge_pkg::uge_reg_t next_enables;

	always_comb begin
		next_enables = usb_event_enables;
		if (wr_take && hit_enables) begin
			next_enables = dat_i[7:0] & `UGE_EVENT_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_irq_o <= 1'b0;
		end else begin
			usb_irq_o <= |(next_flags & next_enables);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			suspended_o <= 1'b0;
		end else begin
			suspended_o <= (link_state == uge_pkg::UGE_LINK_SUSPENDED);
		end
	end

	// bus answer, one cycle after the request
	uge_pkg::uge_reg_t rd_val;

	always_comb begin
		rd_val = 8'h00;
		if (hit_status) begin
			rd_val[`UGE_BIT_SUSPENDED] = (link_state == uge_pkg::UGE_LINK_SUSPENDED);
			rd_val[`UGE_BIT_LINE_IDLE] = line_idle;
			rd_val[`UGE_BIT_IN_RESET]  = in_reset;
			rd_val[`UGE_BIT_RESUMING]  = resuming;
		end else if (hit_flags) begin
			rd_val = usb_event_flags;
		end else if (hit_enables) begin
			rd_val = usb_event_enables;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req & ~ack_o;
			if (req && !ack_o && !we_i) begin
				dat_o <= {24'h00_0000, rd_val};
			end
		end
	end

endmodule : uge_irq

`default_nettype wire

// [verification/uge_irq_chk.sv]
// uge_irq_chk.sv: assertions on the ports of uge_irq.
// assumes: bound to uge_irq; enables mirrored from bus writes.
`timescale 1ns/1ns
`default_nettype none
module uge_irq_chk #(
	parameter int unsigned SUSPEND_CYCLES = 20
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        we_i,
	input wire logic [9:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        line_idle_i,
	input wire logic        bus_reset_i,
	input wire logic        frame_start_toggle_i,
	input wire logic        upstream_resume_i,
	input wire logic        suspended_o,
	input wire logic        usb_irq_o
);
	logic [7:0] en;
	int         idle_n;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			en <= 8'h10;
		else if (ack_o && we_i && sel_i[0] && adr_i[9:2] == 8'hbe)
			en <= dat_i[7:0] & 8'h39;
	end
	always_ff @(posedge clk_i) begin
		idle_n <= (line_idle_i && !bus_reset_i && !rst_i) ? idle_n + 1 : 0;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_rsvd_read_zero: assert property (
		ack_o && !we_i && adr_i[9:2] inside {8'hbd, 8'hbe} |-> (dat_o & ~32'h39) == 0)
		else $error("reserved bits read nonzero");
	a_enables_match: assert property (
		ack_o && !we_i && adr_i[9:2] == 8'hbe |-> dat_o[7:0] == en)
		else $error("enable readback wrong");
	a_frame_irq: assert property (
		en[3] && $changed(frame_start_toggle_i) |-> ##[1:5] usb_irq_o)
		else $error("frame start gave no irq");
	a_reset_end_irq: assert property (
		en[4] && $fell(bus_reset_i) |-> ##[1:5] usb_irq_o)
		else $error("reset end gave no irq");
	a_wake_irq: assert property (
		en[5] && suspended_o && $fell(line_idle_i) && !upstream_resume_i
		|-> ##[1:5] usb_irq_o)
		else $error("wake gave no irq");
	a_masked_quiet: assert property (
		en == 8'h00 ##1 en == 8'h00 |-> !usb_irq_o)
		else $error("irq with all enables off");
	a_idle_suspend: assert property (
		idle_n == SUSPEND_CYCLES + 6 |-> suspended_o && (usb_irq_o || !en[0]))
		else $error("idle bus not suspended");
	a_reset_quiet: assert property (
		disable iff (1'b0) rst_i |=> !usb_irq_o && !ack_o && !suspended_o)
		else $error("outputs active in reset");
endmodule : uge_irq_chk
bind uge_irq uge_irq_chk #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .line_idle_i(line_idle_i),
	.bus_reset_i(bus_reset_i), .frame_start_toggle_i(frame_start_toggle_i),
	.upstream_resume_i(upstream_resume_i), .suspended_o(suspended_o),
	.usb_irq_o(usb_irq_o));
`default_nettype wire

// [verification/uge_host.sv]
// uge_host.sv: line-side model of host and serial engine.
// assumes: drive is called just after a rising edge of clk_i.
`timescale 1ns/1ns
`default_nettype none
module uge_host (
	input  wire logic clk_i,
	output var logic  line_idle_o,
	output var logic  bus_reset_o,
	output var logic  frame_start_toggle_o,
	output var logic  upstream_resume_o
);
	initial begin
		{line_idle_o, bus_reset_o, frame_start_toggle_o, upstream_resume_o} = 4'h0;
	end
	task automatic drive(input logic i, r, f, u, input int n);
		line_idle_o <= i;
		bus_reset_o <= r;
		upstream_resume_o <= u;
		if (f)
			frame_start_toggle_o <= ~frame_start_toggle_o;
		repeat (n) @(posedge clk_i);
	endtask : drive
endmodule : uge_host
`default_nettype wire

// [verification/uge_irq_tb.sv]
// uge_irq_tb.sv: register-level tests of the USB global event block.
// assumes: uge_host drives the line side; checker bound in its own file.
`timescale 1ns/1ns
`default_nettype none
module uge_irq_tb;
	localparam int SC = 20;
	logic        clk, rst, cyc, stb, we, ack, susp, irq, idle, brst, sof, ures;
	logic [9:0]  adr;
	logic [31:0] wdat, rdat, q;
	int          err_count, samples_checked;
	uge_host host (.clk_i(clk), .line_idle_o(idle), .bus_reset_o(brst),
		.frame_start_toggle_o(sof), .upstream_resume_o(ures));
	uge_irq #(.SUSPEND_CYCLES(SC)) uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .line_idle_i(idle), .bus_reset_i(brst), .frame_start_toggle_i(sof),
		.upstream_resume_i(ures), .suspended_o(susp), .usb_irq_o(irq));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
		{cyc, stb, we} <= {2'b11, w};
		adr <= {i, 2'b00};
		wdat <= {24'h0, d};
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rdat;
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		wb(1'b0, i, 8'h00);
		chk(q, {24'h0, e});
	endtask : rd
	task automatic ir(input logic e);
		chk({31'h0, irq}, {31'h0, e});
	endtask : ir
	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		#300000;
		err_count++;
		complete_run();
	end
	initial begin
		{rst, cyc, stb, we, adr, wdat, err_count, samples_checked} = {4'h8, 42'h0, 64'h0};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(8'hbd, 8'h00);
		rd(8'hbe, 8'h10);
		ir(1'b0);
		wb(1'b1, 8'hbe, 8'hff);
		rd(8'hbe, 8'h39);
		rd(8'h10, 8'h00);
		$display("test 1 done");
		host.drive(0, 0, 1, 0, 6);
		rd(8'hbd, 8'h08);
		ir(1'b1);
		wb(1'b1, 8'hbd, 8'hff);
		rd(8'hbd, 8'h08);
		wb(1'b1, 8'hbd, 8'h00);
		rd(8'hbd, 8'h00);
		$display("test 2 done");
		host.drive(0, 1, 0, 0, 4);
		host.drive(0, 0, 0, 0, 6);
		rd(8'hbd, 8'h10);
		ir(1'b1);
		wb(1'b1, 8'hbd, 8'h00);
		ir(1'b0);
		$display("test 3 done");
		host.drive(1, 0, 0, 0, SC + 10);
		rd(8'hbd, 8'h01);
		ir(1'b1);
		rd(8'hbc, 8'h03);
		chk({31'h0, susp}, 32'h0000_0001);
		wb(1'b1, 8'hbd, 8'hfe);
		host.drive(0, 0, 0, 1, 6);
		host.drive(0, 0, 0, 0, 6);
		rd(8'hbd, 8'h00);
		host.drive(1, 0, 0, 0, SC + 10);
		wb(1'b1, 8'hbd, 8'hfe);
		host.drive(0, 0, 0, 0, 6);
		rd(8'hbd, 8'h20);
		ir(1'b1);
		wb(1'b1, 8'hbd, 8'hdf);
		rd(8'hbd, 8'h00);
		$display("test 4 done");
		wb(1'b1, 8'hbe, 8'h00);
		host.drive(0, 0, 1, 0, 6);
		ir(1'b0);
		rd(8'hbd, 8'h08);
		wb(1'b1, 8'hbe, 8'h08);
		ir(1'b1);
		wb(1'b1, 8'hbf, 8'h08);
		ir(1'b0);
		$display("test 5 done");
		complete_run();
	end
endmodule : uge_irq_tb
`default_nettype wire
